// File: pkg/dmst_pkg.sv
// Purpose: Shared constants and types for the debug mode, status and trace block
// Assumes: One clock, synchronous active-low reset
// Notes: Status codes, mode codes and event carriers
package dmst_pkg;
  // ****************************************************
  // Status output encoding
  // ****************************************************
  localparam logic [2:0] ST_HALT = 3'h0;
  localparam logic [2:0] ST_HOLD = 3'h1;
  localparam logic [2:0] ST_LOAD = 3'h2;
  localparam logic [2:0] ST_WAIT = 3'h3;
  localparam logic [2:0] ST_IRET = 3'h4;
  localparam logic [2:0] ST_TRAP = 3'h5;
  localparam logic [2:0] ST_JUMP = 3'h6;
  localparam logic [2:0] ST_EXEC = 3'h7;
  localparam int ST_TOP = 2;

  // ****************************************************
  // Mode control encoding
  // ****************************************************
  localparam logic [1:0] MC_LOAD = 2'h0;
  localparam logic [1:0] MC_STEP = 2'h1;
  localparam logic [1:0] MC_HALT = 2'h2;
  localparam logic [1:0] MC_NORM = 2'h3;
  localparam logic [1:0] MC_RESET_VAL = 2'h3;

  // Mode state machine, one-hot
  typedef enum logic [3:0] {
    DMST_NORMAL = 4'h1,
    DMST_HALTED = 4'h2,
    DMST_STEPPING = 4'h4,
    DMST_LOADING = 4'h8
  } dmst_mode_t;

  // Execute-stage conditions of one internal cycle
  typedef struct packed {
    logic halt;
    logic hold;
    logic load_or_freeze;
    logic wait_cond;
    logic iret;
    logic trap;
    logic jump;
    logic exec;
  } dmst_cond_t;

  // Pipeline events that steer the trace flags
  typedef struct packed {
    logic writeback;
    logic iret;
    logic take_trap;
    logic trap_is_trace;
    logic sup_write;
    logic sup_te;
    logic sup_tp;
    logic supervisor;
  } dmst_evt_t;

  // Trap kinds handled here: saved counter chosen for illegal and assert, protection trap for halt
  typedef struct packed {
    logic illegal_op;
    logic assert_op;
    logic halt_op;
  } dmst_brk_t;
endpackage

// File: core/dmst_core.sv
// Purpose: Trace flags, status output, mode control and breakpoint checks
// Assumes: Execute-stage conditions and pipeline events arrive on mclk_in
// Notes: Mode inputs are asynchronous and synchronised here
//
// Behaviour
// - On write-back copy trace enable into trace pending.
// - Raise trace trap while pending is set, unless traps globally disabled.
// - Interrupt return restores both trace flags from the saved copy.
// - Taking a trace trap clears both current trace flags.
// - Other interrupts or traps save both trace flags to the saved copy.
// - Direct trace flag writes allowed only in supervisor mode.
// - User-mode halt traps, unless mode inputs were 10 during reset.
// - Illegal opcode saves own address; assert saves next address.
// - Three-bit status encodes eight processor conditions.
// - Full rate: show previous cycle condition, earliest code wins.
// - Half rate: first busy, second idle reports first condition.
// - Half rate: both cycles idle reports second condition.
// - Half rate: second cycle return, trap or jump reports it.
// - Multi-cycle work: first cycle executing or trap, later cycles hold.
// - Top status bit low exactly when processor idle.
// - Mode inputs: 00 load, 01 step, 10 halt, 11 normal.
// - Mode inputs are asynchronous and synchronised before use.
// - Violating mode change limits is undefined; reset restores order.
// - Enter requested mode within two or three cycles after access ends.
// - Halt or step: no execution, no accesses, timer frozen.
`timescale 1ns/1ps
module dmst_core (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic mode_control_high_in,
  input wire logic mode_control_low_in,
  input wire logic half_rate_in,
  input wire logic second_phase_in,
  input wire dmst_pkg::dmst_cond_t cond_in,
  input wire logic multi_cont_in,
  input wire dmst_pkg::dmst_evt_t evt_in,
  input wire logic global_trap_disable_in,
  input wire dmst_pkg::dmst_brk_t brk_in,
  input wire logic [31:0] pc_in,
  input wire logic [31:0] pc_next_in,
  input wire logic access_busy_in,
  input wire logic halt_instr_in,
  input wire logic freeze_in,
  output logic trace_enable_flag_out,
  output logic trace_pending_flag_out,
  output logic saved_te_out,
  output logic saved_tp_out,
  output logic trace_trap_out,
  output logic protection_trap_out,
  output logic [31:0] saved_program_counter_out,
  output logic [2:0] status_out,
  output dmst_pkg::dmst_mode_t mode_out,
  output logic run_enable_out,
  output logic timer_enable_out,
  output logic debugger_present_out
);
  import dmst_pkg::*;

  logic [1:0] mc_meta_reg;
  logic [1:0] mc_sync_reg;
  logic [1:0] mc_last_reg;
  logic te_reg;
  logic tp_reg;
  logic ote_reg;
  logic otp_reg;
  logic [2:0] first_code_reg;
  logic [2:0] cur_code;
  logic [2:0] stat_next;
  dmst_mode_t mode_reg;
  dmst_mode_t mode_next;
  logic step_pend_reg;

  // ****************************************************
  // Mode input synchronisers
  // ****************************************************
  // Free-running, so the strap sees the pins while reset is held
  always_ff @(posedge mclk_in)
  begin
    mc_meta_reg <= {mode_control_high_in, mode_control_low_in};
    mc_sync_reg <= mc_meta_reg;
    mc_last_reg <= mc_sync_reg;
  end

  // ****************************************************
  // Debugger strap
  // ****************************************************
  // Captured each reset cycle, held after release
  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      debugger_present_out <= (mc_sync_reg == MC_HALT);
    end
  end

  // ****************************************************
  // Trace flags
  // ****************************************************
  // Priority: trap entry, return, supervisor write, write-back copy
  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      te_reg <= 1'b0;
      tp_reg <= 1'b0;
      ote_reg <= 1'b0;
      otp_reg <= 1'b0;
    end
    else if (evt_in.take_trap)
    begin
      ote_reg <= te_reg;
      otp_reg <= tp_reg;
      te_reg <= 1'b0;
      tp_reg <= 1'b0;
    end
    else if (evt_in.iret)
    begin
      te_reg <= ote_reg;
      tp_reg <= otp_reg;
    end
    else if (evt_in.sup_write && evt_in.supervisor)
    begin
      te_reg <= evt_in.sup_te;
      tp_reg <= evt_in.sup_tp;
    end
    else if (evt_in.writeback)
    begin
      tp_reg <= te_reg;
    end
  end

  // Flag outputs, and trace trap gated by global disable
  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      trace_trap_out <= 1'b0;
      trace_enable_flag_out <= 1'b0;
      trace_pending_flag_out <= 1'b0;
      saved_te_out <= 1'b0;
      saved_tp_out <= 1'b0;
    end
    else
    begin
      trace_trap_out <= tp_reg && !global_trap_disable_in;
      trace_enable_flag_out <= te_reg;
      trace_pending_flag_out <= tp_reg;
      saved_te_out <= ote_reg;
      saved_tp_out <= otp_reg;
    end
  end

  // ****************************************************
  // Breakpoint traps
  // ****************************************************
  // Saved counter choice and user-mode halt protection
  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      saved_program_counter_out <= 32'h0;
      protection_trap_out <= 1'b0;
    end
    else
    begin
      protection_trap_out <= brk_in.halt_op && !evt_in.supervisor
        && !debugger_present_out;
      if (brk_in.illegal_op)
      begin
        saved_program_counter_out <= pc_in;
      end
      else if (brk_in.assert_op)
      begin
        saved_program_counter_out <= pc_next_in;
      end
    end
  end

  // ****************************************************
  // Status encoding
  // ****************************************************
  // Earliest listed condition wins; continuation cycles report hold unless halt is set
  always_comb
  begin
    cur_code = ST_EXEC;
    if (cond_in.halt)
    begin
      cur_code = freeze_in ? ST_LOAD : ST_HALT;
    end
    else if (cond_in.hold || multi_cont_in)
    begin
      cur_code = ST_HOLD;
    end
    else if (cond_in.load_or_freeze)
    begin
      cur_code = ST_LOAD;
    end
    else if (cond_in.wait_cond)
    begin
      cur_code = ST_WAIT;
    end
    else if (cond_in.iret)
    begin
      cur_code = ST_IRET;
    end
    else if (cond_in.trap)
    begin
      cur_code = ST_TRAP;
    end
    else if (cond_in.jump)
    begin
      cur_code = ST_JUMP;
    end
    else
    begin
      cur_code = ST_EXEC;
    end
  end

  // Half-rate choice between first and second internal cycles
  always_comb
  begin
    stat_next = cur_code;
    if (half_rate_in)
    begin
      if (cur_code[ST_TOP] && cur_code != ST_EXEC)
      begin
        stat_next = cur_code;
      end
      else if (first_code_reg[ST_TOP] && !cur_code[ST_TOP])
      begin
        stat_next = first_code_reg;
      end
      else if (!first_code_reg[ST_TOP] && !cur_code[ST_TOP])
      begin
        stat_next = cur_code;
      end
    end
  end

  // First-phase capture and registered status
  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      first_code_reg <= ST_HALT;
      status_out <= ST_HALT;
    end
    else
    begin
      if (!second_phase_in)
      begin
        first_code_reg <= cur_code;
      end
      if (!half_rate_in || second_phase_in)
      begin
        status_out <= stat_next;
      end
    end
  end

  // ****************************************************
  // Mode state machine
  // ****************************************************
  // Waits for outstanding access before leaving normal mode
  always_comb
  begin
    mode_next = mode_reg;
    case (mode_reg)
      DMST_NORMAL:
      begin
        if (!access_busy_in)
        begin
          if (mc_sync_reg == MC_HALT || halt_instr_in)
          begin
            mode_next = DMST_HALTED;
          end
          else if (mc_sync_reg == MC_STEP)
          begin
            mode_next = DMST_STEPPING;
          end
          else if (mc_sync_reg == MC_LOAD)
          begin
            mode_next = DMST_LOADING;
          end
        end
      end
      DMST_HALTED:
      begin
        if (mc_sync_reg == MC_LOAD)
        begin
          mode_next = DMST_LOADING;
        end
        else if (mc_sync_reg == MC_STEP)
        begin
          mode_next = DMST_STEPPING;
        end
        else if (mc_sync_reg == MC_NORM && !halt_instr_in)
        begin
          mode_next = DMST_NORMAL;
        end
      end
      DMST_STEPPING:
      begin
        if (mc_sync_reg == MC_HALT)
        begin
          mode_next = DMST_HALTED;
        end
        else if (mc_sync_reg == MC_LOAD)
        begin
          mode_next = DMST_LOADING;
        end
      end
      DMST_LOADING:
      begin
        if (mc_sync_reg == MC_HALT)
        begin
          mode_next = DMST_HALTED;
        end
        else if (mc_sync_reg == MC_STEP)
        begin
          mode_next = DMST_STEPPING;
        end
      end
      default:
      begin
        mode_next = DMST_NORMAL;
      end
    endcase
  end

  // Mode register and one-cycle step on step-to-normal edge
  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      mode_reg <= DMST_NORMAL;
      step_pend_reg <= 1'b0;
    end
    else
    begin
      mode_reg <= mode_next;
      step_pend_reg <= (mode_reg == DMST_STEPPING)
        && (mc_sync_reg == MC_NORM) && (mc_last_reg == MC_STEP);
    end
  end

  // Run and timer enables follow the mode
  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      mode_out <= DMST_NORMAL;
      run_enable_out <= 1'b1;
      timer_enable_out <= 1'b1;
    end
    else
    begin
      mode_out <= mode_reg;
      run_enable_out <= (mode_reg == DMST_NORMAL) || step_pend_reg;
      timer_enable_out <= (mode_reg == DMST_NORMAL) || step_pend_reg;
    end
  end
endmodule // dmst_core

// File: test/dmst_tester.sv
// Purpose: Tester model driving the two mode pins
// Assumes: Bench names the wanted pin pair
// Notes: One pin per change, four cycles apart
`timescale 1ns/1ps
module dmst_tester (
  input wire logic mclk_in,
  input wire logic [1:0] target_in,
  output logic mode_control_high_out,
  output logic mode_control_low_out
);
  import dmst_pkg::*;
  int gap_reg;
  // Power-up pins at normal operation
  initial
  begin
    mode_control_high_out = 1'b1;
    mode_control_low_out = 1'b1;
    gap_reg = 0;
  end
  // Low pin first, so load never meets normal
  always @(negedge mclk_in)
  begin
    if (gap_reg != 0)
      gap_reg <= gap_reg - 1;
    else if (target_in[0] !== mode_control_low_out)
    begin
      mode_control_low_out <= target_in[0];
      gap_reg <= 3;
    end
    else if (target_in[1] !== mode_control_high_out)
    begin
      mode_control_high_out <= target_in[1];
      gap_reg <= 3;
    end
  end
endmodule // dmst_tester

// File: test/dmst_core_properties.sv
// Purpose: Timing relations at the block's ports
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to the core below
`timescale 1ns/1ps
module dmst_core_chk (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic mode_control_high_in,
  input wire logic mode_control_low_in,
  input wire logic half_rate_in,
  input wire dmst_pkg::dmst_cond_t cond_in,
  input wire dmst_pkg::dmst_evt_t evt_in,
  input wire dmst_pkg::dmst_brk_t brk_in,
  input wire logic [31:0] pc_in,
  input wire logic access_busy_in,
  input wire logic trace_enable_flag_out,
  input wire logic trace_pending_flag_out,
  input wire logic saved_te_out,
  input wire logic trace_trap_out,
  input wire logic protection_trap_out,
  input wire logic [31:0] saved_program_counter_out,
  input wire logic [2:0] status_out,
  input wire dmst_pkg::dmst_mode_t mode_out,
  input wire logic run_enable_out,
  input wire logic timer_enable_out,
  input wire logic debugger_present_out
);
  import dmst_pkg::*;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  // Trace flag movement
  a_trap_needs_pend: assert property (
    trace_trap_out |-> trace_pending_flag_out)
    else $error("trace trap without pending flag");
  a_pend_copy: assert property (
    (evt_in[7:3] == 5'h10) |=> ##1
    trace_pending_flag_out == $past(trace_enable_flag_out))
    else $error("pending flag not copied at write-back");
  a_trap_save_clear: assert property (
    evt_in.take_trap |=> ##1
    saved_te_out == $past(trace_enable_flag_out) &&
    !trace_enable_flag_out && !trace_pending_flag_out)
    else $error("trap entry did not save and clear flags");
  a_iret_restore: assert property (
    (evt_in.iret && !evt_in.take_trap) |=> ##1
    trace_enable_flag_out == $past(saved_te_out))
    else $error("return did not restore enable flag");
  a_user_write_blocked: assert property (
    (evt_in[7:3] == 5'h01 && !evt_in.supervisor) |=> ##1
    $stable(trace_enable_flag_out))
    else $error("user write changed trace flag");
  // Breakpoints
  a_halt_protect: assert property (
    (brk_in.halt_op && !evt_in.supervisor && !debugger_present_out)
    |=> protection_trap_out)
    else $error("user halt not trapped");
  a_illegal_pc: assert property (
    brk_in.illegal_op |=> ##1
    saved_program_counter_out == $past(pc_in, 2))
    else $error("illegal opcode saved wrong address");
  // Status and mode
  a_hold_wins: assert property (
    (!half_rate_in && mode_out == DMST_NORMAL && cond_in == 8'h41)
    |=> status_out == ST_HOLD)
    else $error("earliest condition not reported");
  a_halt_enter: assert property (
    ({mode_control_high_in, mode_control_low_in} == MC_HALT &&
    !access_busy_in) [*5] |-> mode_out == DMST_HALTED)
    else $error("halt not entered in time");
  a_halt_idle: assert property (
    (mode_out == DMST_HALTED) |-> !run_enable_out && !timer_enable_out)
    else $error("running while halted");
  c_trace_trap: cover property (trace_trap_out);
  c_stepping: cover property (mode_out == DMST_STEPPING);
  c_protect: cover property (protection_trap_out);
endmodule // dmst_core_chk
bind dmst_core dmst_core_chk chk_u (.*);

// File: test/dmst_core_tb.sv
// Purpose: Self-checking bench for the debug mode and status core
// Assumes: Inputs change on the falling clock edge
// Notes: Mode pins come from the tester model
`timescale 1ns/1ps
module dmst_core_tb;
  import dmst_pkg::*;
  logic mclk_in, nrst_in, half_rate_in, second_phase_in, dis, mch, mcl;
  logic te, tp, ste, stp, ttrap, ptrap, run, tmr, dbg;
  logic busy, multi, freeze;
  logic [1:0] target;
  logic [2:0] stat;
  logic [31:0] pc, spc;
  dmst_cond_t cond;
  dmst_evt_t evt;
  dmst_brk_t brk;
  dmst_mode_t mode;
  int n_mismatch = 0;
  int n_checks = 0;
  int idle_cnt = 0;
  int run_cnt = 0;
  dmst_tester tester_u (.mclk_in(mclk_in), .target_in(target),
    .mode_control_high_out(mch), .mode_control_low_out(mcl));
  dmst_core dut_u (.mclk_in(mclk_in), .nrst_in(nrst_in),
    .mode_control_high_in(mch), .mode_control_low_in(mcl),
    .half_rate_in(half_rate_in), .second_phase_in(second_phase_in),
    .cond_in(cond), .multi_cont_in(multi), .evt_in(evt),
    .global_trap_disable_in(dis), .brk_in(brk), .pc_in(pc),
    .pc_next_in(pc + 32'h4), .access_busy_in(busy),
    .halt_instr_in(1'b0), .freeze_in(freeze),
    .trace_enable_flag_out(te), .trace_pending_flag_out(tp),
    .saved_te_out(ste), .saved_tp_out(stp), .trace_trap_out(ttrap),
    .protection_trap_out(ptrap), .saved_program_counter_out(spc),
    .status_out(stat), .mode_out(mode), .run_enable_out(run),
    .timer_enable_out(tmr), .debugger_present_out(dbg));
  // Clock
  initial
  begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end
  // Idle run on the top status bit; run cycles seen while stepping
  always @(posedge mclk_in)
  begin
    idle_cnt <= stat[ST_TOP] ? 0 : idle_cnt + 1;
    if (run && mode == DMST_STEPPING)
      run_cnt <= run_cnt + 1;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge mclk_in);
  endtask
  // One event or breakpoint cycle; supervisor level stays
  task automatic fire(input dmst_evt_t e, input dmst_brk_t b);
    evt = e;
    brk = b;
    tick(1);
    evt = e & 8'h01;
    brk = 3'h0;
    tick(1);
  endtask
  task automatic half(input dmst_cond_t c1, input dmst_cond_t c2);
    second_phase_in = 1'b0;
    cond = c1;
    tick(1);
    second_phase_in = 1'b1;
    cond = c2;
    tick(1);
    second_phase_in = 1'b0;
  endtask
  task automatic go(input logic [1:0] t, input dmst_mode_t m);
    target = t;
    tick(16);
    check(mode, m);
  endtask
  task automatic give_verdict;
    if (n_mismatch == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    #(5000 * 5);
    n_mismatch++;
    give_verdict();
  end
  // Main sequence
  initial
  begin
    nrst_in = 1'b0;
    {half_rate_in, second_phase_in, dis, busy, multi, freeze} = 6'h00;
    target = 2'h3;
    cond = 8'h00;
    evt = 8'h00;
    brk = 3'h0;
    pc = 32'h100;
    tick(3);
    nrst_in = 1'b1;
    check(dbg, 0);
    fire(8'h0D, 3'h0);
    check({te, tp}, 2'h2);
    fire(8'h81, 3'h0);
    tick(1);
    check({tp, ttrap}, 2'h3);
    dis = 1'b1;
    tick(2);
    check(ttrap, 0);
    dis = 1'b0;
    fire(8'h31, 3'h0);
    check({te, tp, ste, stp}, 4'h3);
    fire(8'h0C, 3'h0);
    check(te, 0);
    fire(8'h40, 3'h0);
    check({te, tp}, 2'h3);
    fire(8'h21, 3'h0);
    fire(8'h0D, 3'h0);
    fire(8'h21, 3'h0);
    check({ste, stp}, 2'h2);
    fire(8'h40, 3'h0);
    fire(8'h80, 3'h0);
    check({te, tp, ttrap}, 3'h7);
    for (int i = 0; i < 8; i++)
    begin
      cond = 8'h80 >> i;
      tick(1);
      check(stat, i);
      if (i == 3)
        check(idle_cnt, 3);
    end
    cond = 8'h41;
    tick(1);
    check(stat, ST_HOLD);
    {multi, cond} = 9'h101;
    tick(1);
    check(stat, ST_HOLD);
    {multi, freeze, cond} = 10'h180;
    tick(1);
    check(stat, ST_LOAD);
    freeze = 1'b0;
    half_rate_in = 1'b1;
    half(8'h01, 8'h10);
    check(stat, ST_EXEC);
    half(8'h40, 8'h10);
    check(stat, ST_WAIT);
    half(8'h01, 8'h02);
    check(stat, ST_JUMP);
    half_rate_in = 1'b0;
    cond = 8'h00;
    fire(8'h00, 3'h4);
    check(spc, 32'h100);
    fire(8'h00, 3'h2);
    check(spc, 32'h104);
    brk = 3'h1;
    tick(1);
    brk = 3'h0;
    check(ptrap, 1);
    busy = 1'b1;
    go(2'h2, DMST_NORMAL);
    busy = 1'b0;
    go(2'h2, DMST_HALTED);
    check({run, tmr}, 2'h0);
    go(2'h0, DMST_LOADING);
    go(2'h2, DMST_HALTED);
    go(2'h3, DMST_NORMAL);
    go(2'h1, DMST_STEPPING);
    go(2'h3, DMST_STEPPING);
    check(run_cnt, 1);
    go(2'h2, DMST_HALTED);
    nrst_in = 1'b0;
    tick(4);
    nrst_in = 1'b1;
    tick(1);
    check(dbg, 1);
    brk = 3'h1;
    tick(1);
    brk = 3'h0;
    check(ptrap, 0);
    go(2'h3, DMST_NORMAL);
    give_verdict();
  end
endmodule // dmst_core_tb
